/* File: bench/i2c_peer_model.sv */
// far-side model: the i2c bus peer as the port's byte shifter reports it
// assumes tasks are called by the bench; every change lands just after a rising edge
`default_nettype none
module i2c_peer_model (
   input wire logic core_clk, // system clock
   input wire logic sclOe, // port pulls the clock wire low
   output logic sclIn, // clock wire level
   output logic sdaIn, // data wire level
   output logic rxByteDone, // byte received pulse
   output logic [7:0] rxByte, // received byte
   output logic txShifting, // word going out
   output logic busFree, // bus allows a start
   output logic addrMatch, // address matched pulse
   output logic matchDir, // matched direction, 1 read
   output logic addrNeedsReload, // second address half pending
   output logic startSeen, // start pulse
   output logic stopSeen, // stop pulse
   output logic nackSeen, // nack pulse
   output logic seqDone // sequence finished pulse
);
   timeunit 1ns;
   timeprecision 1ns;
   // both wires have pull-ups and the peer only releases them here
   assign sclIn = ~sclOe;
   assign sdaIn = 1'b1;
   initial begin
      {rxByteDone, txShifting, busFree, addrMatch, matchDir} = 5'h00;
      {startSeen, stopSeen, nackSeen} = 3'h0;
      {addrNeedsReload, seqDone} = 2'h0;
      rxByte = 8'h00;
   end
   // one received byte; stale data is inverted so nothing can lean on it
   task automatic rx(input logic [7:0] b);
      @(posedge core_clk);
      rxByteDone <= 1'b1;
      rxByte <= b;
      @(posedge core_clk);
      rxByteDone <= 1'b0;
      rxByte <= ~b;
   endtask : rx
   // address match, direction stays as a level afterwards
   task automatic match(input logic dir);
      @(posedge core_clk);
      addrMatch <= 1'b1;
      matchDir <= dir;
      @(posedge core_clk);
      addrMatch <= 1'b0;
   endtask : match
   // one bus condition pulse, given as {start, stop, nack}
   task automatic cond(input logic [2:0] which);
      @(posedge core_clk);
      {startSeen, stopSeen, nackSeen} <= which;
      @(posedge core_clk);
      {startSeen, stopSeen, nackSeen} <= 3'h0;
   endtask : cond
   task automatic done();
      @(posedge core_clk);
      seqDone <= 1'b1;
      @(posedge core_clk);
      seqDone <= 1'b0;
   endtask : done
   task automatic levels(input logic tx, input logic free, input logic reload);
      @(posedge core_clk);
      txShifting <= tx;
      busFree <= free;
      addrNeedsReload <= reload;
   endtask : levels
endmodule : i2c_peer_model
`default_nettype wire

/* File: bench/i2c_port_status_control_test.sv */
// self-checking bench for the serial port status and control block
// assumes one ahb-lite master here, a single slave, and the peer model beside it
`default_nettype none
module i2c_port_status_control_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk, reset, hsel, hwrite, hready, hresp, sclOe, sclHoldLow;
   logic [7:0] haddr, txWord, rxByte;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] hwdata, hrdata;
   logic sclIn, sdaIn, rxByteDone, txShifting, busFree, addrMatch, matchDir;
   logic addrNeedsReload, startSeen, stopSeen, nackSeen, seqDone, portOwnsPins;
   logic txLoad, baudTick, masterMode, slaveMode, slaveTen, startStopIntEn, portBusy;
   int badCount = 0;
   int compares = 0;
   int cycles = 0;
   int n;
   logic [3:0] m;
   logic sl;
   i2c_port_status_control dut_u (.core_clk(core_clk), .reset(reset), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .sclIn(sclIn),
      .sdaIn(sdaIn), .rxByteDone(rxByteDone), .rxByte(rxByte), .txShifting(txShifting),
      .busFree(busFree), .addrMatch(addrMatch), .matchDir(matchDir),
      .addrNeedsReload(addrNeedsReload), .startSeen(startSeen), .stopSeen(stopSeen),
      .nackSeen(nackSeen), .seqDone(seqDone), .portOwnsPins(portOwnsPins),
      .sclHoldLow(sclHoldLow), .sclOe(sclOe), .txWord(txWord), .txLoad(txLoad),
      .baudTick(baudTick), .masterMode(masterMode), .slaveMode(slaveMode),
      .slaveTen(slaveTen), .startStopIntEn(startStopIntEn), .portBusy(portBusy));
   i2c_peer_model peer_u (.core_clk(core_clk), .sclOe(sclOe), .sclIn(sclIn), .sdaIn(sdaIn),
      .rxByteDone(rxByteDone), .rxByte(rxByte), .txShifting(txShifting), .busFree(busFree),
      .addrMatch(addrMatch), .matchDir(matchDir), .addrNeedsReload(addrNeedsReload),
      .startSeen(startSeen), .stopSeen(stopSeen), .nackSeen(nackSeen), .seqDone(seqDone));
   ////////////////////////////////////////////////////////////////////////////////
   // clock, reset and a ceiling far above the roughly 400 cycles the tests need
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 8000) begin
         badCount++;
         giveVerdict();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         badCount++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask : check
   // one single word transfer; waits only on hready, the timeout ends a hang
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
      @(posedge core_clk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= i2c_port_pkg::HTRANS_NONSEQ;
      // hready and read data are taken at the rising edge, before the slave's update lands
      do @(posedge core_clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge core_clk); while (hready !== 1'b1);
      rd = hrdata;
   endtask : xfer
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      xfer(1'b1, a, d, x);
   endtask : wr
   task automatic rdm(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] e);
      logic [31:0] x;
      xfer(1'b0, a, 32'h0, x);
      check(x & mask, e);
   endtask : rdm
   // registered outputs are built from the next register value, so they change on the same edge as the register
   task automatic settle();
      repeat (2) @(negedge core_clk);
   endtask : settle
   task automatic giveVerdict();
      if (badCount == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : giveVerdict
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {reset, hsel, hwrite, htrans, haddr, hwdata} = {1'b1, 44'h0};
      hsize = i2c_port_pkg::HSIZE_WORD;
      repeat (16) @(posedge core_clk);
      reset <= 1'b0;
      rdm(i2c_port_pkg::CTRL_ONE_ADDR, 32'hffffffff, 32'h00);
      rdm(i2c_port_pkg::STATUS_ADDR, 32'h07, 32'h00);
      check(32'(portOwnsPins), 32'h0);
      check(32'(hresp), 32'h0);
      // every mode code, clock release both ways
      for (int i = 0; i < 32; i++) begin
         m = i[3:0];
         wr(i2c_port_pkg::CTRL_ONE_ADDR, {26'h0, 1'b1, i[4], m});
         settle();
         sl = (m == 4'hf || m == 4'he || m == 4'h7 || m == 4'h6);
         check(32'(masterMode), 32'(m == 4'h8 || m == 4'hb));
         check(32'(slaveMode), 32'(sl));
         check(32'(slaveTen), 32'(m == 4'hf || m == 4'h7));
         check(32'(startStopIntEn), 32'(sl & m[3]));
         check(32'(sclHoldLow), 32'(sl & ~i[4]));
         check(32'(portOwnsPins), 32'h1);
      end
      wr(i2c_port_pkg::CTRL_ONE_ADDR, 32'h00);
      settle();
      check(32'({portOwnsPins, sclOe}), 32'h0);
      // slave receive: full, then overflow drops the second byte
      wr(i2c_port_pkg::CTRL_ONE_ADDR, 32'h36);
      peer_u.match(1'b0);
      peer_u.rx(8'h5a);
      rdm(i2c_port_pkg::STATUS_ADDR, 32'h05, 32'h01);
      peer_u.rx(8'ha5);
      rdm(i2c_port_pkg::CTRL_ONE_ADDR, 32'hff, 32'h76);
      rdm(i2c_port_pkg::DATA_ADDR, 32'hff, 32'h5a);
      rdm(i2c_port_pkg::STATUS_ADDR, 32'h01, 32'h00);
      wr(i2c_port_pkg::CTRL_ONE_ADDR, 32'h36);
      rdm(i2c_port_pkg::CTRL_ONE_ADDR, 32'hff, 32'h36);
      // slave transmit: a write while shifting collides
      peer_u.match(1'b1);
      rdm(i2c_port_pkg::STATUS_ADDR, 32'h04, 32'h04);
      peer_u.levels(1'b1, 1'b0, 1'b0);
      wr(i2c_port_pkg::DATA_ADDR, 32'h3c);
      @(negedge core_clk);
      check(32'({txLoad, txWord}), 32'h13c);
      settle();
      check(32'(txLoad), 32'h0);
      rdm(i2c_port_pkg::CTRL_ONE_ADDR, 32'hc0, 32'h80);
      wr(i2c_port_pkg::CTRL_ONE_ADDR, 32'h36);
      peer_u.levels(1'b0, 1'b0, 1'b0);
      wr(i2c_port_pkg::DATA_ADDR, 32'hc3);
      rdm(i2c_port_pkg::CTRL_ONE_ADDR, 32'h80, 32'h00);
      // start, stop and nack each end the direction of the last match
      for (int c = 0; c < 3; c++) begin
         peer_u.match(1'b1);
         peer_u.cond(3'h1 << c);
         rdm(i2c_port_pkg::STATUS_ADDR, 32'h04, 32'h00);
      end
      // ten-bit slave asks for an address reload
      wr(i2c_port_pkg::CTRL_ONE_ADDR, 32'h37);
      peer_u.levels(1'b0, 1'b0, 1'b1);
      settle();
      rdm(i2c_port_pkg::STATUS_ADDR, 32'h02, 32'h02);
      peer_u.levels(1'b0, 1'b0, 1'b0);
      settle();
      rdm(i2c_port_pkg::STATUS_ADDR, 32'h02, 32'h00);
      // hardware master: collision only while the bus is not free
      wr(i2c_port_pkg::CTRL_ONE_ADDR, 32'h28);
      wr(i2c_port_pkg::DATA_ADDR, 32'h11);
      rdm(i2c_port_pkg::CTRL_ONE_ADDR, 32'h80, 32'h80);
      wr(i2c_port_pkg::CTRL_ONE_ADDR, 32'h28);
      peer_u.levels(1'b0, 1'b1, 1'b0);
      wr(i2c_port_pkg::DATA_ADDR, 32'h22);
      rdm(i2c_port_pkg::CTRL_ONE_ADDR, 32'h80, 32'h00);
      // each sequence trigger, and transmit alone, marks the port busy
      for (int b = 0; b < 5; b++) begin
         wr(i2c_port_pkg::SEQ_ADDR, 32'h1 << b);
         settle();
         check(32'(portBusy), 32'h1);
         peer_u.done();
         settle();
         check(32'(portBusy), 32'h0);
         rdm(i2c_port_pkg::SEQ_ADDR, 32'hff, 32'h00);
      end
      peer_u.levels(1'b1, 1'b1, 1'b0);
      settle();
      check(32'(portBusy), 32'h1);
      peer_u.levels(1'b0, 1'b1, 1'b0);
      settle();
      check(32'(portBusy), 32'h0);
      // quarter-bit tick spacing is reload plus one
      wr(i2c_port_pkg::RELOAD_ADDR, 32'h02);
      rdm(i2c_port_pkg::RELOAD_ADDR, 32'hff, 32'h02);
      do @(negedge core_clk); while (baudTick !== 1'b1);
      n = 0;
      do begin
         @(negedge core_clk);
         n++;
      end while (baudTick !== 1'b1);
      check(32'(n), 32'h3);
      // unmapped place reads zero and takes no write
      wr(8'h40, 32'hff);
      rdm(8'h40, 32'hffffffff, 32'h0);
      rdm(i2c_port_pkg::CTRL_ONE_ADDR, 32'hff, 32'h28);
      giveVerdict();
   end
endmodule : i2c_port_status_control_test
`default_nettype wire

/* File: src/i2c_port_pkg.sv */
// package for the serial port status and control block, i2c mode
// assumes an ahb-lite slave at word offsets and a 10 MHz core clock
`default_nettype none
package i2c_port_pkg;
   // byte addresses on the bus
   localparam logic [7:0] CTRL_ONE_ADDR = 8'h00;
   localparam logic [7:0] STATUS_ADDR = 8'h04;
   localparam logic [7:0] DATA_ADDR = 8'h08;
   localparam logic [7:0] RELOAD_ADDR = 8'h0c;
   localparam logic [7:0] SEQ_ADDR = 8'h10;
   // control register fields
   localparam int WRITE_COLLISION_FLAG_BIT = 7;
   localparam int OVF_BIT = 6;
   localparam int EN_BIT = 5;
   localparam int CKREL_BIT = 4;
   localparam logic [7:0] CTRL_ONE_RESET = 8'h00;
   // status register fields
   localparam int RW_BIT = 2;
   localparam int UA_BIT = 1;
   localparam int BF_BIT = 0;
   // sequence trigger register fields
   localparam int SEQ_START = 0;
   localparam int SEQ_RSTART = 1;
   localparam int SEQ_STOP = 2;
   localparam int SEQ_RECV = 3;
   localparam int SEQ_ACK = 4;
   // mode codes
   localparam logic [3:0] MODE_SLV10_INT = 4'hf;
   localparam logic [3:0] MODE_SLV7_INT = 4'he;
   localparam logic [3:0] MODE_FW_MASTER = 4'hb;
   localparam logic [3:0] MODE_HW_MASTER = 4'h8;
   localparam logic [3:0] MODE_SLV10 = 4'h7;
   localparam logic [3:0] MODE_SLV7 = 4'h6;
   // ahb encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   // one bus clock has four quarter phases
   localparam logic [9:0] QUARTERS_PER_BIT = 10'h004;
endpackage : i2c_port_pkg
`default_nettype wire

/* File: src/i2c_port_status_control.sv */
// status and control logic of the serial port in i2c mode
// assumes a single ahb-lite master and a shifter that reports byte events
`default_nettype none
module i2c_port_status_control (
   input wire logic core_clk, // 10 MHz system clock
   input wire logic reset, // synchronous, active high
   input wire logic hsel, // slave select
   input wire logic [7:0] haddr, // byte address
   input wire logic [1:0] htrans, // transfer type
   input wire logic hwrite, // write access
   input wire logic [2:0] hsize, // transfer size
   input wire logic [31:0] hwdata, // write data
   input wire logic hready, // bus ready
   output logic [31:0] hrdata, // read data
   output logic hreadyout, // slave ready
   output logic hresp, // always okay
   input wire logic sclIn, // clock pin level
   input wire logic sdaIn, // data pin level
   input wire logic rxByteDone, // shifter finished a received byte
   input wire logic [7:0] rxByte, // byte from the shifter
   input wire logic txShifting, // shifter is sending a word
   input wire logic busFree, // master: bus allows a start
   input wire logic addrMatch, // slave: address matched, pulse
   input wire logic matchDir, // direction of matched address
   input wire logic addrNeedsReload, // 10-bit slave address phase pending
   input wire logic startSeen, // start condition detected
   input wire logic stopSeen, // stop condition detected
   input wire logic nackSeen, // non-acknowledge seen
   input wire logic seqDone, // shifter finished the current sequence
   output logic portOwnsPins, // pins are serial port pins
   output logic sclHoldLow, // drive clock low for stretch
   output logic sclOe, // clock pin output enable
   output logic [7:0] txWord, // word to send
   output logic txLoad, // pulse: load shifter
   output logic baudTick, // quarter bit tick in hardware master
   output logic masterMode, // a master mode is selected
   output logic slaveMode, // a slave mode is selected
   output logic slaveTen, // 10-bit slave mode
   output logic startStopIntEn, // start and stop interrupts enabled
   output logic portBusy // master busy indication
);
   ////////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic [1:0] sclSync_reg, sclSync_next;
   logic [1:0] sdaSync_reg, sdaSync_next;
   always_comb begin
      sclSync_next = {sclSync_reg[0], sclIn};
      sdaSync_next = {sdaSync_reg[0], sdaIn};
   end
   always_ff @(posedge core_clk) begin
      if (reset) begin
         sclSync_reg <= 2'h3;
         sdaSync_reg <= 2'h3;
      end else begin
         sclSync_reg <= sclSync_next;
         sdaSync_reg <= sdaSync_next;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // mode decode, shared by several places
   function automatic logic isSlave(input logic [3:0] m);
      isSlave = (m == i2c_port_pkg::MODE_SLV10_INT) || (m == i2c_port_pkg::MODE_SLV7_INT)
         || (m == i2c_port_pkg::MODE_SLV10) || (m == i2c_port_pkg::MODE_SLV7);
   endfunction : isSlave
   function automatic logic isMaster(input logic [3:0] m);
      isMaster = (m == i2c_port_pkg::MODE_HW_MASTER) || (m == i2c_port_pkg::MODE_FW_MASTER);
   endfunction : isMaster
   function automatic logic slaveTenMode(input logic [3:0] m);
      slaveTenMode = (m == i2c_port_pkg::MODE_SLV10_INT) || (m == i2c_port_pkg::MODE_SLV10);
   endfunction : slaveTenMode

   ////////////////////////////////////////////////////////////////////
   // bus address phase capture
   logic wrPend_reg, wrPend_next;
   logic [7:0] wrAddr_reg, wrAddr_next;
   logic rdPend_reg, rdPend_next;
   logic [7:0] rdAddr_reg, rdAddr_next;
   logic take;
   assign take = hsel && hready && (htrans == i2c_port_pkg::HTRANS_NONSEQ)
      && (hsize == i2c_port_pkg::HSIZE_WORD);
   always_comb begin
      wrPend_next = take && hwrite;
      rdPend_next = take && !hwrite;
      wrAddr_next = take ? haddr : wrAddr_reg;
      rdAddr_next = take ? haddr : rdAddr_reg;
   end
   always_ff @(posedge core_clk) begin
      if (reset) begin
         wrPend_reg <= 1'b0;
         rdPend_reg <= 1'b0;
         wrAddr_reg <= 8'h00;
         rdAddr_reg <= 8'h00;
      end else begin
         wrPend_reg <= wrPend_next;
         rdPend_reg <= rdPend_next;
         wrAddr_reg <= wrAddr_next;
         rdAddr_reg <= rdAddr_next;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // register state
   logic [7:0] ctrl_reg, ctrl_next;
   logic [7:0] buf_reg, buf_next;
   logic [7:0] reload_reg, reload_next;
   logic [4:0] seq_reg, seq_next;
   logic full_reg, full_next;
   logic rw_reg, rw_next;
   logic ua_reg, ua_next;
   logic [3:0] mode;
   logic wrCtrl, wrData, wrReload, wrSeq, rdData;
   logic slv, mst, txDir;
   assign mode = ctrl_reg[3:0];
   assign slv = isSlave(mode);
   assign mst = isMaster(mode);
   assign txDir = slv ? rw_reg : !seq_reg[i2c_port_pkg::SEQ_RECV]; // current direction
   assign wrCtrl = wrPend_reg && (wrAddr_reg == i2c_port_pkg::CTRL_ONE_ADDR);
   assign wrData = wrPend_reg && (wrAddr_reg == i2c_port_pkg::DATA_ADDR);
   assign wrReload = wrPend_reg && (wrAddr_reg == i2c_port_pkg::RELOAD_ADDR);
   assign wrSeq = wrPend_reg && (wrAddr_reg == i2c_port_pkg::SEQ_ADDR);
   assign rdData = take && !hwrite && (haddr == i2c_port_pkg::DATA_ADDR);

   // flags: hardware set wins over a software clear in the same cycle
   always_comb begin
      ctrl_next = ctrl_reg;
      buf_next = buf_reg;
      reload_next = reload_reg;
      seq_next = seq_reg;
      full_next = full_reg;
      rw_next = rw_reg;
      ua_next = ua_reg;
      if (wrCtrl) begin
         ctrl_next = hwdata[7:0];
      end
      if (wrReload) begin
         reload_next = hwdata[7:0];
      end
      if (wrSeq) begin
         seq_next = hwdata[4:0];
      end else if (seqDone) begin
         seq_next = 5'h00; // triggers self-clear when the sequence ends
      end
      if (wrData) begin
         buf_next = hwdata[7:0];
         if (mst && txDir && !busFree) begin
            ctrl_next[i2c_port_pkg::WRITE_COLLISION_FLAG_BIT] = 1'b1;
         end
         if (slv && txDir && txShifting) begin
            ctrl_next[i2c_port_pkg::WRITE_COLLISION_FLAG_BIT] = 1'b1;
         end
      end
      if (rdData) begin
         full_next = 1'b0; // reading the buffer empties it
      end
      if (rxByteDone && !txDir) begin
         if (full_reg && !rdData) begin
            ctrl_next[i2c_port_pkg::OVF_BIT] = 1'b1;
         end else begin
            buf_next = rxByte;
            full_next = 1'b1;
         end
      end
      if (slv && addrMatch) begin
         rw_next = matchDir;
      end else if (startSeen || stopSeen || nackSeen) begin
         rw_next = 1'b0;
      end
      ua_next = slaveTenMode(mode) && addrNeedsReload;
      if (!ctrl_reg[i2c_port_pkg::EN_BIT]) begin
         full_next = 1'b0;
         rw_next = 1'b0;
         ua_next = 1'b0;
      end
   end
   always_ff @(posedge core_clk) begin
      if (reset) begin
         ctrl_reg <= i2c_port_pkg::CTRL_ONE_RESET;
         buf_reg <= 8'h00;
         reload_reg <= 8'h00;
         seq_reg <= 5'h00;
         full_reg <= 1'b0;
         rw_reg <= 1'b0;
         ua_reg <= 1'b0;
      end else begin
         ctrl_reg <= ctrl_next;
         buf_reg <= buf_next;
         reload_reg <= reload_next;
         seq_reg <= seq_next;
         full_reg <= full_next;
         rw_reg <= rw_next;
         ua_reg <= ua_next;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // baud divider: a quarter-bit tick every reload+1 cycles gives
   // a bus clock of core over 4*(reload+1)
   logic [7:0] baudCnt_reg, baudCnt_next;
   logic tick_reg, tick_next;
   logic hwMaster;
   assign hwMaster = ctrl_reg[i2c_port_pkg::EN_BIT] && (mode == i2c_port_pkg::MODE_HW_MASTER);
   always_comb begin
      baudCnt_next = 8'h00;
      tick_next = 1'b0;
      if (hwMaster) begin
         if (baudCnt_reg >= reload_reg) begin
            tick_next = 1'b1;
         end else begin
            baudCnt_next = baudCnt_reg + 8'h01;
         end
      end
   end
   always_ff @(posedge core_clk) begin
      if (reset) begin
         baudCnt_reg <= 8'h00;
         tick_reg <= 1'b0;
      end else begin
         baudCnt_reg <= baudCnt_next;
         tick_reg <= tick_next;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // registered outputs
   logic [31:0] rdat_reg, rdat_next;
   logic own_reg, own_next, hold_reg, hold_next, load_reg, load_next;
   logic mm_reg, mm_next, sm_reg, sm_next, st_reg, st_next, ss_reg, ss_next, busy_reg, busy_next;
   always_comb begin
      rdat_next = 32'h0000_0000;
      if (rdPend_next) begin
         if (haddr == i2c_port_pkg::CTRL_ONE_ADDR) begin
            rdat_next = {24'h000000, ctrl_next};
         end else if (haddr == i2c_port_pkg::STATUS_ADDR) begin
            rdat_next = {29'h00000000, rw_next, ua_next, full_next};
         end else if (haddr == i2c_port_pkg::DATA_ADDR) begin
            rdat_next = {24'h000000, buf_reg};
         end else if (haddr == i2c_port_pkg::RELOAD_ADDR) begin
            rdat_next = {24'h000000, reload_next};
         end else if (haddr == i2c_port_pkg::SEQ_ADDR) begin
            rdat_next = {27'h0000000, seq_next};
         end
      end
      own_next = ctrl_next[i2c_port_pkg::EN_BIT];
      // invalid codes select neither role, so no stretch or busy, but the port still owns the pins
      sm_next = own_next && isSlave(ctrl_next[3:0]);
      mm_next = own_next && isMaster(ctrl_next[3:0]);
      st_next = own_next && slaveTenMode(ctrl_next[3:0]);
      ss_next = own_next && ((ctrl_next[3:0] == i2c_port_pkg::MODE_SLV10_INT)
         || (ctrl_next[3:0] == i2c_port_pkg::MODE_SLV7_INT));
      hold_next = sm_next && !ctrl_next[i2c_port_pkg::CKREL_BIT];
      load_next = wrData && own_reg;
      busy_next = mm_next && (txShifting || (|seq_next));
   end
   always_ff @(posedge core_clk) begin
      if (reset) begin
         rdat_reg <= 32'h0000_0000;
         own_reg <= 1'b0;
         hold_reg <= 1'b0;
         load_reg <= 1'b0;
         mm_reg <= 1'b0;
         sm_reg <= 1'b0;
         st_reg <= 1'b0;
         ss_reg <= 1'b0;
         busy_reg <= 1'b0;
      end else begin
         rdat_reg <= rdat_next;
         own_reg <= own_next;
         hold_reg <= hold_next;
         load_reg <= load_next;
         mm_reg <= mm_next;
         sm_reg <= sm_next;
         st_reg <= st_next;
         ss_reg <= ss_next;
         busy_reg <= busy_next;
      end
   end
   assign hrdata = rdat_reg;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign portOwnsPins = own_reg;
   assign sclHoldLow = hold_reg;
   assign sclOe = hold_reg;
   assign txWord = buf_reg;
   assign txLoad = load_reg;
   assign baudTick = tick_reg;
   assign masterMode = mm_reg;
   assign slaveMode = sm_reg;
   assign slaveTen = st_reg;
   assign startStopIntEn = ss_reg;
   assign portBusy = busy_reg;

   ////////////////////////////////////////////////////////////////////
   // checks
   a_write_collision_flag_master: assert property (@(posedge core_clk) disable iff (reset)
      wrData && mst && txDir && !busFree |=> ctrl_reg[i2c_port_pkg::WRITE_COLLISION_FLAG_BIT])
      else $error("master write collision missed");
   a_write_collision_flag_slave: assert property (@(posedge core_clk) disable iff (reset)
      wrData && slv && txDir && txShifting |=> ctrl_reg[i2c_port_pkg::WRITE_COLLISION_FLAG_BIT])
      else $error("slave write collision missed");
   a_ovf_set: assert property (@(posedge core_clk) disable iff (reset)
      rxByteDone && !txDir && full_reg && !rdData && !wrData |=> ctrl_reg[i2c_port_pkg::OVF_BIT]
         && $stable(buf_reg))
      else $error("overflow missed");
   a_pins_owned: assert property (@(posedge core_clk) disable iff (reset)
      portOwnsPins == ctrl_reg[i2c_port_pkg::EN_BIT])
      else $error("pin ownership wrong");
   a_clk_stretch: assert property (@(posedge core_clk) disable iff (reset)
      sclHoldLow |-> slaveMode && portOwnsPins)
      else $error("stretch outside slave mode");
   a_invalid_mode: assert property (@(posedge core_clk) disable iff (reset)
      !(masterMode && slaveMode))
      else $error("two roles at once");
   a_busy_or: assert property (@(posedge core_clk) disable iff (reset)
      masterMode && (|seq_reg) && !wrSeq && !wrCtrl && !seqDone |=> portBusy)
      else $error("busy not shown");
   a_full_set: assert property (@(posedge core_clk) disable iff (reset)
      rxByteDone && !txDir && !full_reg && ctrl_reg[i2c_port_pkg::EN_BIT] |=> full_reg)
      else $error("buffer full not set");
   a_baud_period: assert property (@(posedge core_clk) disable iff (reset)
      // a zero reload legally ticks every cycle, so only longer periods are checked
      baudTick && hwMaster && (reload_reg != 8'h00) |=> !baudTick)
      else $error("baud tick too close");
   c_overflow: cover property (@(posedge core_clk) ctrl_reg[i2c_port_pkg::OVF_BIT]);
   c_collision: cover property (@(posedge core_clk) ctrl_reg[i2c_port_pkg::WRITE_COLLISION_FLAG_BIT]);
   c_stretch: cover property (@(posedge core_clk) sclHoldLow);
   c_tick: cover property (@(posedge core_clk) baudTick);
endmodule : i2c_port_status_control
`default_nettype wire
